// File: logic/vmps_defs.vh
`ifndef VMPS_DEFS_VH
`define VMPS_DEFS_VH

// ==========================================================
// register indices (byte address is four times the index)
`define VMPS_IDX_CRTC_INDEX 10'h3d4
`define VMPS_IDX_CRTC_DATA 10'h3d5
`define VMPS_IDX_MODE 10'h3d8
`define VMPS_IDX_COLOUR 10'h3d9
`define VMPS_IDX_STATUS 10'h3e0
`define VMPS_IDX_EXTRA 10'h3e1

// ==========================================================
// apb address split
`define VMPS_ADDR_W 12
`define VMPS_IDX_HI 11
`define VMPS_IDX_LO 2
`define VMPS_BYTE_OFS 2'h0

// ==========================================================
// video mode control fields
`define VMPS_MODE_BLINK 5
`define VMPS_MODE_HIRES 4
`define VMPS_MODE_VIDEN 3
`define VMPS_MODE_MONO 2
`define VMPS_MODE_GRAPH 1
`define VMPS_MODE_FASTCK 0

// ==========================================================
// colour select fields
`define VMPS_COL_PALSET 5
`define VMPS_COL_BGI 4
`define VMPS_COL_BORDER_HI 3
`define VMPS_COL_BORDER_LO 0

// ==========================================================
// extra mode fields
`define VMPS_EXTRA_C16 0
`define VMPS_EXTRA_C4HR 1
`define VMPS_EXTRA_MASK 8'h03

// ==========================================================
// status fields
`define VMPS_STAT_MODE_HI 5
`define VMPS_STAT_MODE_LO 0
`define VMPS_STAT_CIDX_HI 15
`define VMPS_STAT_CIDX_LO 8

// ==========================================================
// display controller register count
`define VMPS_CRTC_REGS 8'h12

// ==========================================================
// reset values
`define VMPS_RST_MODE 8'h00
`define VMPS_RST_COLOUR 8'h00
`define VMPS_RST_EXTRA 8'h00
`define VMPS_RST_CIDX 8'h00

// ==========================================================
// one-hot display modes
`define VMPS_M_OFF 6'h01
`define VMPS_M_TEXT 6'h02
`define VMPS_M_G2 6'h04
`define VMPS_M_G4LO 6'h08
`define VMPS_M_G4HI 6'h10
`define VMPS_M_G16 6'h20

`endif

// File: logic/vmps_pixel_map.v
`timescale 1ns/1ps
`include "vmps_defs.vh"

// ==========================================================
// pixel bits to palette index and rgbi colour
module vmps_pixel_map (
    input wire [5:0] mode_i,
    input wire [3:0] pix_bits_i,
    input wire [3:0] text_bg_i,
    input wire pix_fg_i,
    input wire blink_attr_i,
    input wire blink_phase_i,
    input wire border_i,
    input wire blink_en_i,
    input wire mono_i,
    input wire [7:0] colour_i,
    output reg [3:0] index_o,
    output reg [3:0] rgbi_o
);

    wire [3:0] border_col = colour_i[`VMPS_COL_BORDER_HI:`VMPS_COL_BORDER_LO];
    wire bg_int = colour_i[`VMPS_COL_BGI];
    wire pal_set = colour_i[`VMPS_COL_PALSET];
    reg [3:0] bg_col;
    reg blank_fg;

    // ==========================================================
    // mode dependent mapping
    always @* begin
        index_o = 4'h0;
        rgbi_o = 4'h0;
        bg_col = text_bg_i;
        blank_fg = 1'b0;
        case (mode_i)
            `VMPS_M_TEXT: begin
                if (blink_en_i) begin
                    bg_col = {bg_int, text_bg_i[2:0]};
                    blank_fg = blink_attr_i & blink_phase_i;
                end else begin
                    bg_col = text_bg_i;
                end
                if (border_i) begin
                    index_o = border_col;
                end else if (pix_fg_i & ~blank_fg) begin
                    index_o = pix_bits_i;
                end else begin
                    index_o = bg_col;
                end
                rgbi_o = index_o;
            end
            `VMPS_M_G2: begin
                index_o = {3'h0, pix_bits_i[0]};
                rgbi_o = pix_bits_i[0] ? border_col : 4'h0;
                if (border_i) begin
                    rgbi_o = 4'h0;
                end
            end
            `VMPS_M_G4LO: begin
                index_o = {2'h0, pix_bits_i[1:0]};
                if (pix_bits_i[1:0] == 2'h0) begin
                    rgbi_o = border_col;
                end else begin
                    // blue from palette set, or alternate set when mono
                    rgbi_o = {bg_int, pix_bits_i[1], pix_bits_i[0],
                        mono_i ? pix_bits_i[0] : pal_set};
                end
                if (border_i) begin
                    rgbi_o = border_col;
                end
            end
            `VMPS_M_G4HI: begin
                index_o = {2'h0, pix_bits_i[1:0]};
                rgbi_o = index_o;
            end
            `VMPS_M_G16: begin
                index_o = pix_bits_i;
                rgbi_o = pix_bits_i;
            end
            default: begin
                index_o = 4'h0;
                rgbi_o = 4'h0;
            end
        endcase
    end

endmodule // vmps_pixel_map

// File: logic/vmps_top.v
`timescale 1ns/1ps
`include "vmps_defs.vh"

// What this block does
// - two-colour modes use pixel bit 0 as palette index 0 or 1.
// - four-colour modes use pixel bits 1 and 0, high first, index 0 to 3.
// - sixteen-colour modes use four pixel bits IRGB as index 0 to 15.
// - blink enabled blinks characters with attribute bit 7, limits backgrounds.
// - blink disabled means attribute bit 7 gives all 16 backgrounds.
// - hires graphics bit selects 640 by 200 two or four colour graphics.
// - display output only while video enable bit is one.
// - mono bit picks mono output, or alternate palette in 320 four-colour.
// - graphics select bit picks text at zero, graphics at one.
// - dot clock bit picks slow clock at zero, fast clock at one.
// - palette set bit drives blue of fixed 320 four-colour set.
// - text with blink takes background intensity from colour select.
// - 320 four-colour foreground intensity comes from background intensity bit.
// - text mode border uses colour select border IRGB bits.
// - 320 four-colour pixels 00 take colour select border IRGB as background.
// - 640 two-colour foreground pixels use colour select border IRGB.
module vmps_top (
    input wire CLK_I,
    input wire ARST_N_I,
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [11:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    output wire [31:0] PRDATA_O,
    output wire PREADY_O,
    output wire PSLVERR_O,
    input wire PIX_VALID_I,
    input wire [3:0] PIX_BITS_I,
    input wire [3:0] TEXT_BG_I,
    input wire PIX_FG_I,
    input wire BLINK_ATTR_I,
    input wire BLINK_PHASE_I,
    input wire BORDER_I,
    output wire PIX_VALID_O,
    output wire [3:0] PAL_INDEX_O,
    output wire [3:0] RGBI_O,
    output wire VIDEO_ON_O,
    output wire MONO_O,
    output wire GRAPHICS_O,
    output wire HIRES_O,
    output wire FAST_DOT_CLK_O,
    output wire BLINK_EN_O,
    output wire CRTC_WE_O,
    output wire [7:0] CRTC_ADDR_O,
    output wire [7:0] CRTC_DATA_O
);

    // ==========================================================
    // helper functions
    function idx_hit;
        input [11:0] addr;
        input [9:0] idx;
        begin
            idx_hit = (addr[`VMPS_IDX_HI:`VMPS_IDX_LO] == idx) &&
                (addr[1:0] == `VMPS_BYTE_OFS);
        end
    endfunction

    function [31:0] byte_word;
        input [7:0] value;
        begin
            byte_word = {24'h000000, value};
        end
    endfunction

    // ==========================================================
    // display mode states
    localparam [5:0] ST_OFF = `VMPS_M_OFF;
    localparam [5:0] ST_TEXT = `VMPS_M_TEXT;
    localparam [5:0] ST_G2 = `VMPS_M_G2;
    localparam [5:0] ST_G4LO = `VMPS_M_G4LO;
    localparam [5:0] ST_G4HI = `VMPS_M_G4HI;
    localparam [5:0] ST_G16 = `VMPS_M_G16;

    // ==========================================================
    // declarations
    reg [7:0] mode_reg;
    reg [7:0] colour_reg;
    reg [7:0] extra_reg;
    reg [7:0] cidx_reg;
    reg [5:0] state_reg;
    reg [5:0] state_next;
    reg [31:0] prdata_reg;
    reg [31:0] prdata_next;
    reg pready_reg;
    reg pslverr_reg;
    reg pslverr_next;
    reg crtc_we_reg;
    reg [7:0] crtc_addr_reg;
    reg [7:0] crtc_data_reg;
    reg pix_valid_reg;
    reg [3:0] pal_index_reg;
    reg [3:0] rgbi_reg;
    reg video_on_reg;
    reg mono_reg;
    reg graphics_reg;
    reg hires_reg;
    reg fast_clk_reg;
    reg blink_en_reg;
    wire setup_phase;
    wire access_edge;
    wire wr_edge;
    wire mapped;
    wire [3:0] map_index;
    wire [3:0] map_rgbi;
    wire [15:0] status_word;
    wire hit_cidx;
    wire hit_cdata;
    wire hit_mode;
    wire hit_colour;
    wire hit_status;
    wire hit_extra;

    // ==========================================================
    // apb phase decode
    assign setup_phase = PSEL_I & ~PENABLE_I;
    assign access_edge = PSEL_I & PENABLE_I & pready_reg;
    assign wr_edge = access_edge & PWRITE_I;

    // register select decode, one strobe per mapped word
    assign hit_cidx = idx_hit(PADDR_I, `VMPS_IDX_CRTC_INDEX);
    assign hit_cdata = idx_hit(PADDR_I, `VMPS_IDX_CRTC_DATA);
    assign hit_mode = idx_hit(PADDR_I, `VMPS_IDX_MODE);
    assign hit_colour = idx_hit(PADDR_I, `VMPS_IDX_COLOUR);
    assign hit_status = idx_hit(PADDR_I, `VMPS_IDX_STATUS);
    assign hit_extra = idx_hit(PADDR_I, `VMPS_IDX_EXTRA);

    // address map check, anything else is refused with an error
    assign mapped = hit_cidx |
        hit_cdata |
        hit_mode |
        hit_colour |
        hit_status |
        hit_extra;

    // status readback of live mode and controller index
    assign status_word = {cidx_reg, 2'h0, state_reg};

    // ==========================================================
    // read data and error, sampled in the setup cycle
    always @* begin
        prdata_next = 32'h00000000;
        pslverr_next = ~mapped;
        if (PWRITE_I) begin
            // status is read only
            if (hit_status) begin
                pslverr_next = 1'b1;
            end
        end else if (hit_status) begin
            prdata_next = {16'h0000, status_word};
        end else if (hit_extra) begin
            prdata_next = byte_word(extra_reg);
        end
    end

    // ==========================================================
    // apb answer, one wait state free access phase
    always @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else begin
            pready_reg <= setup_phase;
            if (setup_phase) begin
                pslverr_reg <= pslverr_next;
                prdata_reg <= prdata_next;
            end else if (access_edge) begin
                // clear after the access so no stale word is left on the bus
                pslverr_reg <= 1'b0;
                prdata_reg <= 32'h00000000;
            end
        end
    end

    // ==========================================================
    // mode, colour and extra register writes
    always @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            mode_reg <= `VMPS_RST_MODE;
            colour_reg <= `VMPS_RST_COLOUR;
            extra_reg <= `VMPS_RST_EXTRA;
        end else if (wr_edge) begin
            if (hit_mode) begin
                mode_reg <= PWDATA_I[7:0];
            end
            if (hit_colour) begin
                colour_reg <= PWDATA_I[7:0];
            end
            if (hit_extra) begin
                // unused extra bits are dropped so they read back as zero
                extra_reg <= PWDATA_I[7:0] & `VMPS_EXTRA_MASK;
            end
        end
    end

    // ==========================================================
    // display controller index and data ports
    always @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            cidx_reg <= `VMPS_RST_CIDX;
            crtc_we_reg <= 1'b0;
            crtc_addr_reg <= 8'h00;
            crtc_data_reg <= 8'h00;
        end else begin
            crtc_we_reg <= 1'b0;
            if (wr_edge && hit_cidx) begin
                cidx_reg <= PWDATA_I[7:0];
            end
            // data lands in the register picked by the last index write
            // an index of 18 or more leaves the controller untouched
            if (wr_edge && hit_cdata &&
                (cidx_reg < `VMPS_CRTC_REGS)) begin
                crtc_we_reg <= 1'b1;
                crtc_addr_reg <= cidx_reg;
                crtc_data_reg <= PWDATA_I[7:0];
            end
        end
    end

    // ==========================================================
    // display mode selection
    always @* begin
        state_next = ST_OFF;
        if (!mode_reg[`VMPS_MODE_VIDEN]) begin
            state_next = ST_OFF;
        end else if (!mode_reg[`VMPS_MODE_GRAPH]) begin
            state_next = ST_TEXT;
        end else if (extra_reg[`VMPS_EXTRA_C16]) begin
            state_next = ST_G16;
        end else if (mode_reg[`VMPS_MODE_HIRES]) begin
            // 640 wide is two colour unless the four colour option is set
            if (extra_reg[`VMPS_EXTRA_C4HR]) begin
                state_next = ST_G4HI;
            end else begin
                state_next = ST_G2;
            end
        end else begin
            state_next = ST_G4LO;
        end
    end

    // mode state register
    // any stray code falls back to off, so the display stays dark
    always @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state_reg <= ST_OFF;
        end else begin
            case (state_next)
                ST_OFF: state_reg <= ST_OFF;
                ST_TEXT: state_reg <= ST_TEXT;
                ST_G2: state_reg <= ST_G2;
                ST_G4LO: state_reg <= ST_G4LO;
                ST_G4HI: state_reg <= ST_G4HI;
                ST_G16: state_reg <= ST_G16;
                default: state_reg <= ST_OFF;
            endcase
        end
    end

    // ==========================================================
    // pixel mapping
    vmps_pixel_map u_map (
        .mode_i(state_reg),
        .pix_bits_i(PIX_BITS_I),
        .text_bg_i(TEXT_BG_I),
        .pix_fg_i(PIX_FG_I),
        .blink_attr_i(BLINK_ATTR_I),
        .blink_phase_i(BLINK_PHASE_I),
        .border_i(BORDER_I),
        .blink_en_i(mode_reg[`VMPS_MODE_BLINK]),
        .mono_i(mode_reg[`VMPS_MODE_MONO]),
        .colour_i(colour_reg),
        .index_o(map_index),
        .rgbi_o(map_rgbi)
    );

    // ==========================================================
    // registered pixel output, blanked while video is off
    always @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            pix_valid_reg <= 1'b0;
            pal_index_reg <= 4'h0;
            rgbi_reg <= 4'h0;
        end else begin
            pix_valid_reg <= PIX_VALID_I;
            if (PIX_VALID_I && (state_reg != ST_OFF)) begin
                pal_index_reg <= map_index;
                rgbi_reg <= map_rgbi;
            end else begin
                pal_index_reg <= 4'h0;
                rgbi_reg <= 4'h0;
            end
        end
    end

    // ==========================================================
    // mode flags towards the timing and monitor logic
    always @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            video_on_reg <= 1'b0;
            mono_reg <= 1'b0;
            graphics_reg <= 1'b0;
            hires_reg <= 1'b0;
            fast_clk_reg <= 1'b0;
            blink_en_reg <= 1'b0;
        end else begin
            video_on_reg <= mode_reg[`VMPS_MODE_VIDEN];
            mono_reg <= mode_reg[`VMPS_MODE_MONO];
            graphics_reg <= mode_reg[`VMPS_MODE_GRAPH];
            hires_reg <= mode_reg[`VMPS_MODE_HIRES];
            fast_clk_reg <= mode_reg[`VMPS_MODE_FASTCK];
            // blinking only applies to text
            blink_en_reg <= mode_reg[`VMPS_MODE_BLINK] &
                ~mode_reg[`VMPS_MODE_GRAPH];
        end
    end

    // ==========================================================
    // output wiring
    assign PRDATA_O = prdata_reg;
    assign PREADY_O = pready_reg;
    assign PSLVERR_O = pslverr_reg;
    assign PIX_VALID_O = pix_valid_reg;
    assign PAL_INDEX_O = pal_index_reg;
    assign RGBI_O = rgbi_reg;
    assign VIDEO_ON_O = video_on_reg;
    assign MONO_O = mono_reg;
    assign GRAPHICS_O = graphics_reg;
    assign HIRES_O = hires_reg;
    assign FAST_DOT_CLK_O = fast_clk_reg;
    assign BLINK_EN_O = blink_en_reg;
    assign CRTC_WE_O = crtc_we_reg;
    assign CRTC_ADDR_O = crtc_addr_reg;
    assign CRTC_DATA_O = crtc_data_reg;

endmodule // vmps_top

// File: sim/vmps_assertions.sv
`timescale 1ns/1ps
// ====
// port checker for the mode and palette block
module vmps_assertions (
    input logic CLK_I,
    input logic ARST_N_I,
    input logic PSEL_I,
    input logic PENABLE_I,
    input logic PWRITE_I,
    input logic [11:0] PADDR_I,
    input logic [31:0] PWDATA_I,
    input logic [31:0] PRDATA_O,
    input logic PREADY_O,
    input logic PSLVERR_O,
    input logic PIX_VALID_I,
    input logic [3:0] PAL_INDEX_O,
    input logic [3:0] RGBI_O,
    input logic VIDEO_ON_O,
    input logic MONO_O,
    input logic GRAPHICS_O,
    input logic HIRES_O,
    input logic FAST_DOT_CLK_O,
    input logic BLINK_EN_O,
    input logic CRTC_WE_O,
    input logic [7:0] CRTC_ADDR_O,
    input logic [7:0] CRTC_DATA_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!ARST_N_I);
    // bus phase decode
    wire setup = PSEL_I && !PENABLE_I;
    wire acc = PSEL_I && PENABLE_I && PREADY_O;
    wire mapped = PADDR_I inside {12'hf50, 12'hf54, 12'hf60, 12'hf64, 12'hf80, 12'hf84};
    wire st_wr = PWRITE_I && PADDR_I == 12'hf80;
    // controller index as software last wrote it
    logic [7:0] cidx_seen;
    always @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            cidx_seen <= 8'h00;
        end else if (acc && PWRITE_I && PADDR_I == 12'hf50) begin
            cidx_seen <= PWDATA_I[7:0];
        end
    end
    wire dat_wr = acc && PWRITE_I && PADDR_I == 12'hf54 && cidx_seen < 8'h12;
    sequence s_mode_wr;
        acc && PWRITE_I && PADDR_I == 12'hf60;
    endsequence
    // mode byte reaches the flag outputs two edges after acceptance
    property p_mode;
        logic [7:0] d;
        (s_mode_wr, d = PWDATA_I[7:0]) |-> ##2 (VIDEO_ON_O == d[3] && MONO_O == d[2]
            && GRAPHICS_O == d[1] && HIRES_O == d[4] && FAST_DOT_CLK_O == d[0]
            && BLINK_EN_O == (d[5] && !d[1]));
    endproperty
    a_ready_pulse: assert property (setup |=> PREADY_O ##1 !PREADY_O)
        else $error("ready is not a single access cycle");
    a_unmapped_err: assert property (setup && !mapped |=> PSLVERR_O && PRDATA_O == 32'h0)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (setup && mapped && !st_wr |=> !PSLVERR_O)
        else $error("mapped access refused");
    a_status_ro: assert property (setup && st_wr |=> PSLVERR_O)
        else $error("status write not refused");
    a_err_ready: assert property (PSLVERR_O |-> PREADY_O)
        else $error("error outside access");
    a_rdata_idle: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
        else $error("read data outside access");
    a_mode_flags: assert property (p_mode)
        else $error("mode flags do not follow mode write");
    a_crtc_pulse: assert property (dat_wr |=> CRTC_WE_O
        && CRTC_DATA_O == $past(PWDATA_I[7:0]) && CRTC_ADDR_O == $past(cidx_seen))
        else $error("controller data write lost");
    a_crtc_refuse: assert property (!dat_wr |=> !CRTC_WE_O)
        else $error("spurious controller strobe");
    a_video_dark: assert property (!PIX_VALID_I || !VIDEO_ON_O |=> RGBI_O == 4'h0
        && PAL_INDEX_O == 4'h0) else $error("pixel shown while dark");
endmodule // vmps_assertions

bind vmps_top vmps_assertions u_chk (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .PIX_VALID_I(PIX_VALID_I), .PAL_INDEX_O(PAL_INDEX_O), .RGBI_O(RGBI_O),
    .VIDEO_ON_O(VIDEO_ON_O), .MONO_O(MONO_O), .GRAPHICS_O(GRAPHICS_O), .HIRES_O(HIRES_O),
    .FAST_DOT_CLK_O(FAST_DOT_CLK_O), .BLINK_EN_O(BLINK_EN_O), .CRTC_WE_O(CRTC_WE_O),
    .CRTC_ADDR_O(CRTC_ADDR_O), .CRTC_DATA_O(CRTC_DATA_O));

// File: sim/vmps_monitor.sv
`timescale 1ns/1ps
// ====
// display sink: counts pixels it is handed
module vmps_monitor (
    input logic clk_i,
    input logic arst_n_i,
    input logic valid_i,
    input logic [3:0] rgbi_i,
    output int count_o,
    output logic [3:0] last_o
);
    // take one colour per strobed cycle
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count_o <= 0;
            last_o <= 4'h0;
        end else if (valid_i) begin
            count_o <= count_o + 1;
            last_o <= rgbi_i;
        end
    end
endmodule // vmps_monitor

// File: sim/vmps_top_tb.sv
`timescale 1ns/1ps
// ====
// register and pixel path bench
module vmps_top_tb;
    logic clk, arst_n = 0, psel = 0, pen = 0, pwr = 0, pv = 0, pfg = 0, bat = 0, bph = 0, bo = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, rd;
    logic [3:0] pbits = 4'h0, tbg = 4'h0;
    wire [31:0] prdata;
    wire [3:0] pidx, rgbi, mlast;
    wire [7:0] caddr, cdata;
    wire pready, pslverr, pvo, von, mono, graphics_select, hires, fck, blen, cwe;
    logic e;
    logic [7:0] we_a, we_d;
    int failures = 0, n_tests = 0, n_pix = 0, n_we = 0, mcount;
    logic [7:0] mt [8] = '{8'h00, 8'h29, 8'h1a, 8'h0e, 8'h1a, 8'h0a, 8'h08, 8'h17};
    logic [7:0] xt [8] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h2, 8'h1, 8'h1, 8'h0};
    logic [5:0] st [8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h02, 6'h01};
    vmps_top u_dut (.CLK_I(clk), .ARST_N_I(arst_n), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .PIX_VALID_I(pv), .PIX_BITS_I(pbits),
        .TEXT_BG_I(tbg), .PIX_FG_I(pfg), .BLINK_ATTR_I(bat), .BLINK_PHASE_I(bph),
        .BORDER_I(bo), .PIX_VALID_O(pvo), .PAL_INDEX_O(pidx), .RGBI_O(rgbi),
        .VIDEO_ON_O(von), .MONO_O(mono), .GRAPHICS_O(graphics_select), .HIRES_O(hires),
        .FAST_DOT_CLK_O(fck), .BLINK_EN_O(blen), .CRTC_WE_O(cwe), .CRTC_ADDR_O(caddr),
        .CRTC_DATA_O(cdata));
    vmps_monitor u_mon (.clk_i(clk), .arst_n_i(arst_n), .valid_i(pvo), .rgbi_i(rgbi),
        .count_o(mcount), .last_o(mlast));
    // ====
    // clock and controller strobe capture
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        if (cwe === 1'b1) begin
            n_we++;
            we_a = caddr;
            we_d = cdata;
        end
    end
    // ====
    // helpers
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task complete_run();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pen <= 0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1;
        // only the watchdog ends a wait for the answer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 0;
        pen <= 0;
    endtask
    task rchk(input logic [11:0] a, input logic [31:0] x, input logic xe);
        apb(0, a, 0);
        check("rdata", rd, x);
        check("slverr", e, xe);
    endtask
    task mode(input logic [7:0] m, input logic [7:0] c, input logic [7:0] x);
        apb(1, 12'hf60, m);
        apb(1, 12'hf64, c);
        apb(1, 12'hf84, x);
        repeat (2) @(posedge clk);
    endtask
    task pix(input logic [3:0] b, input logic f, input logic at, input logic ph, input logic br,
        input logic [3:0] xr, input logic [3:0] xi);
        @(posedge clk);
        pv <= 1;
        pbits <= b;
        tbg <= 4'ha;
        pfg <= f;
        bat <= at;
        bph <= ph;
        bo <= br;
        @(posedge clk);
        pv <= 0;
        n_pix++;
        #1;
        check("rgbi", rgbi, xr);
        check("index", pidx, xi);
    endtask
    // ====
    // watchdog and main sequence
    initial begin
        #100000;
        failures++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1;
        rchk(12'hf80, 32'h1, 0);
        rchk(12'hf60, 32'h0, 0);
        rchk(12'hf64, 32'h0, 0);
        rchk(12'hf58, 32'h0, 1);
        apb(1, 12'hf80, 32'hff);
        check("status wr err", e, 1);
        apb(1, 12'hf84, 32'hff);
        rchk(12'hf84, 32'h3, 0);
        apb(1, 12'hf50, 32'h05);
        apb(1, 12'hf54, 32'h28);
        apb(1, 12'hf50, 32'h11);
        apb(1, 12'hf54, 32'h77);
        @(posedge clk);
        #1;
        check("crtc strobe", {we_a, we_d, n_we[7:0]}, 24'h117702);
        apb(1, 12'hf50, 32'h12);
        apb(1, 12'hf54, 32'h66);
        @(posedge clk);
        #1;
        check("crtc refused", n_we, 2);
        for (int i = 0; i < 8; i++) begin
            mode(mt[i], 8'h00, xt[i]);
            rchk(12'hf80, {18'h0048, st[i]}, 0);
            check("flags", {blen, hires, von, mono, graphics_select, fck},
                {mt[i][5] & ~mt[i][1], mt[i][4], mt[i][3:0]});
        end
        mode(8'h08, 8'h1c, 0);
        pix(4'h5, 1, 0, 0, 1, 4'hc, 4'hc);
        pix(4'h5, 0, 0, 0, 0, 4'ha, 4'ha);
        pix(4'h5, 1, 1, 1, 0, 4'h5, 4'h5);
        mode(8'h28, 8'h0c, 0);
        pix(4'h5, 0, 0, 0, 0, 4'h2, 4'h2);
        pix(4'h5, 1, 1, 1, 0, 4'h2, 4'h2);
        pix(4'h5, 1, 1, 0, 0, 4'h5, 4'h5);
        mode(8'h28, 8'h1c, 0);
        pix(4'h5, 0, 0, 0, 0, 4'ha, 4'ha);
        mode(8'h1a, 8'h0c, 0);
        pix(4'h1, 0, 0, 0, 0, 4'hc, 4'h1);
        pix(4'he, 0, 0, 0, 0, 4'h0, 4'h0);
        mode(8'h0a, 8'h39, 0);
        pix(4'h0, 0, 0, 0, 0, 4'h9, 4'h0);
        pix(4'h2, 0, 0, 0, 0, 4'hd, 4'h2);
        pix(4'hd, 0, 0, 0, 0, 4'hb, 4'h1);
        mode(8'h0e, 8'h29, 0);
        pix(4'h2, 0, 0, 0, 0, 4'h4, 4'h2);
        pix(4'h3, 0, 0, 0, 0, 4'h7, 4'h3);
        mode(8'h0a, 8'h09, 0);
        pix(4'h1, 0, 0, 0, 0, 4'h2, 4'h1);
        mode(8'h1a, 8'h00, 8'h2);
        for (int i = 0; i < 4; i++) pix(4'hc | i[3:0], 0, 0, 0, 0, i[3:0], i[3:0]);
        mode(8'h0a, 8'h00, 8'h1);
        for (int i = 0; i < 16; i++) pix(i[3:0], 0, 0, 0, 0, i[3:0], i[3:0]);
        mode(8'h02, 8'h0f, 0);
        pix(4'hf, 0, 0, 0, 0, 4'h0, 4'h0);
        @(posedge clk);
        #1;
        check("monitor count", mcount, n_pix);
        check("monitor last", mlast, 4'h0);
        complete_run();
    end
endmodule // vmps_top_tb
